// ===== video_out_pkg.sv
package video_out_pkg;

   // ==========================================================
   // register map
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;

   // ==========================================================
   // control word field positions
   localparam int CLK_SRC_LSB     = 28;
   localparam int IN_DIV_LSB      = 25;
   localparam int FB_DIV_LSB      = 22;
   localparam int CLK_DRIVE_BIT   = 21;
   localparam int SYNC_MASTER_BIT = 20;
   localparam int LINE_POL_BIT    = 19;
   localparam int FRAME_POL_BIT   = 18;
   localparam int OVERLAY_BIT     = 17;
   localparam int MODE_LSB        = 14;
   localparam int REL1_BIT        = 13;
   localparam int REL2_BIT        = 12;
   localparam int BW_CLR_BIT      = 11;
   localparam int UNDERRUN_FLAG_CLR_BIT    = 10;
   localparam int ENABLE_BIT      = 0;

   // status word field positions
   localparam int ST_DRAINED1_BIT = 0;
   localparam int ST_DRAINED2_BIT = 1;
   localparam int ST_BW_ERR_BIT   = 2;
   localparam int ST_UNDERRUN_FLAG_BIT     = 3;
   localparam int ST_ACTIVE2_BIT  = 4;

   // ==========================================================
   // reset values
   localparam logic [1:0]  CLK_SRC_RESET  = 2'h3;
   localparam logic [2:0]  IN_DIV_RESET   = 3'h1;
   localparam logic [2:0]  FB_DIV_RESET   = 3'h1;
   localparam logic [31:0] CTRL_RESET     = 32'h3240_0000;

   // ==========================================================
   // clock source codes
   typedef enum logic [1:0] {
      SRC_PLL_VCO = 2'b00,
      SRC_FB_DIV  = 2'b01,
      SRC_IN_DIV  = 2'b10,
      SRC_SYNTH   = 2'b11
   } clk_src_t;

   // major modes; codes with the top bit clear are refresh modes
   typedef enum logic [2:0] {
      MODE_REFRESH_A = 3'b000,
      MODE_REFRESH_B = 3'b001,
      MODE_REFRESH_C = 3'b010,
      MODE_REFRESH_D = 3'b011,
      MODE_MESSAGE   = 3'b100,
      MODE_STREAM    = 3'b101
   } mode_t;

   // settings handed to the pll macro
   typedef struct packed {
      clk_src_t   src;
      logic [3:0] in_ratio;
      logic [3:0] fb_ratio;
   } pll_cfg_t;

   // driven half of a two-way pin
   typedef struct packed {
      logic o;
      logic oe_n;
   } pin_out_t;

endpackage

// ===== video_out_control_fields.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - clock source code picks pixel clock origin
// - source field resets to synthesizer bypass
// - input divider ratio is value plus one
// - feedback divider ratio is value plus one
// - drive enable set drives pixel clock out
// - drive enable clear takes external clock
// - sync master drives both sync pins
// - without sync master frame pin is input
// - frame polarity picks falling or rising edge
// - line polarity bit stored, no function
// - overlay acts only in refresh modes
// - mode field selects major mode
// - buffer release clears drained, enables buffer
// - stream enable releases both buffers
// - message enable releases only buffer one
// - error clear bits drop matching flags
// - stream underrun keeps previous buffer
module video_out_control_fields
   import video_out_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    pll_vco_clk,
   input  wire logic                    pll_fb_div_clk,
   input  wire logic                    pll_in_div_clk,
   input  wire logic                    synth_clk,
   output video_out_pkg::pll_cfg_t      pll_cfg,
   input  wire logic                    pixel_clock_i,
   output video_out_pkg::pin_out_t      pixel_clock_pin,
   output logic                         unit_clock,
   input  wire logic                    line_sync_i,
   output video_out_pkg::pin_out_t      line_sync_pin,
   input  wire logic                    frame_sync_i,
   output video_out_pkg::pin_out_t      frame_sync_pin,
   input  wire logic                    line_timing,
   input  wire logic                    frame_timing,
   input  wire logic                    msg_start,
   input  wire logic                    msg_end,
   output logic                         frame_ref_pulse,
   output logic                         overlay_active,
   output video_out_pkg::mode_t         mode,
   output logic                         unit_enable,
   input  wire logic                    buffer_done,
   input  wire logic                    bandwidth_error_evt,
   input  wire logic                    refresh_underrun_evt,
   output logic      [1:0]              buffer_ready,
   output logic                         second_buffer_active
);
   import video_out_pkg::*;

   // ==========================================================
   // bus decode
   logic        wr_en;
   logic        ctrl_sel;
   logic        stat_sel;
   logic        ctrl_wr;
   logic [31:0] prdata_d;

   assign ctrl_sel = (paddr == CTRL_OFFSET);
   assign stat_sel = (paddr == STATUS_OFFSET);
   assign wr_en    = psel & penable & pwrite;
   assign ctrl_wr  = wr_en & ctrl_sel;
   // status is read-only: a write there is taken and ignored
   // zero wait states; unmapped addresses answer with an error
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~(ctrl_sel | stat_sel);

   // ==========================================================
   // stored control fields
   clk_src_t   clk_src_q;
   logic [2:0] in_div_q;
   logic [2:0] fb_div_q;
   logic       drive_q;
   logic       sync_master_q;
   logic       line_pol_q;
   logic       frame_pol_q;
   logic       overlay_q;
   mode_t      mode_q;
   logic       enable_q;

   // the whole word is taken on each write; software writes back the rest
   // reset to bypass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_src_q     <= SRC_SYNTH;
         in_div_q      <= IN_DIV_RESET;
         fb_div_q      <= FB_DIV_RESET;
         drive_q       <= 1'b0;
         sync_master_q <= 1'b0;
         line_pol_q    <= 1'b0;
         frame_pol_q   <= 1'b0;
         overlay_q     <= 1'b0;
         mode_q        <= MODE_REFRESH_A;
         enable_q      <= 1'b0;
      end else if (ctrl_wr) begin
         clk_src_q     <= clk_src_t'(pwdata[CLK_SRC_LSB +: 2]);
         in_div_q      <= pwdata[IN_DIV_LSB +: 3];
         fb_div_q      <= pwdata[FB_DIV_LSB +: 3];
         drive_q       <= pwdata[CLK_DRIVE_BIT];
         sync_master_q <= pwdata[SYNC_MASTER_BIT];
         line_pol_q    <= pwdata[LINE_POL_BIT];
         frame_pol_q   <= pwdata[FRAME_POL_BIT];
         overlay_q     <= pwdata[OVERLAY_BIT];
         mode_q        <= mode_t'(pwdata[MODE_LSB +: 3]);
         enable_q      <= pwdata[ENABLE_BIT];
      end
   end

   // codes 6 and 7 are neither refresh nor transfer: the unit idles
   logic is_refresh;
   logic is_stream;
   logic is_message;
   assign is_refresh = ~mode_q[2];
   assign is_stream  = (mode_q == MODE_STREAM);
   assign is_message = (mode_q == MODE_MESSAGE);

   // ==========================================================
   // write-one actions; these are pulses, never stored
   // they act through the flags below and leave nothing to read back
   logic rel1;
   logic rel2;
   logic bw_clr;
   logic underrun_flag_clr;
   logic en_wr1;

   // enable doubles as a release in the transfer modes
   assign en_wr1   = ctrl_wr & pwdata[ENABLE_BIT];
   assign rel1     = (is_stream | is_message) &
                     ((ctrl_wr & pwdata[REL1_BIT]) | en_wr1);
   assign rel2     = is_stream &
                     ((ctrl_wr & pwdata[REL2_BIT]) | en_wr1);
   assign bw_clr   = ctrl_wr & pwdata[BW_CLR_BIT];
   assign underrun_flag_clr = ctrl_wr & pwdata[UNDERRUN_FLAG_CLR_BIT];

   // ==========================================================
   // buffer bookkeeping
   logic drained1_q;
   logic drained2_q;
   logic active2_q;
   logic bw_err_q;
   logic underrun_flag_q;
   logic done_evt;
   logic next_ok;
   logic stream_underrun_flag;

   // a finish outside the transfer modes is dropped, so a stray pulse
   // during refresh cannot drain a buffer
   assign done_evt    = buffer_done & (is_stream | is_message);
   // only buffer one is used for messages
   // in stream mode the next buffer is the one not active
   assign next_ok     = is_stream &
                        (active2_q ? ~drained1_q : ~drained2_q);
   assign stream_underrun_flag = buffer_done & is_stream & ~next_ok;

   // drained flags; a finish in the release cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drained1_q <= 1'b1;
         drained2_q <= 1'b1;
      end else begin
         if (done_evt & ~active2_q)
            drained1_q <= 1'b1;
         else if (rel1)
            drained1_q <= 1'b0;
         if (done_evt & active2_q)
            drained2_q <= 1'b1;
         else if (rel2)
            drained2_q <= 1'b0;
      end
   end

   // leaving stream mode restarts on buffer one
   // switch only when next is released
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active2_q <= 1'b0;
      end else if (!is_stream) begin
         active2_q <= 1'b0;
      end else if (buffer_done && next_ok) begin
         active2_q <= ~active2_q;
      end
   end

   // an event landing with the clear must not be lost
   // error flags; new event beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bw_err_q <= 1'b0;
         underrun_flag_q   <= 1'b0;
      end else begin
         if (bandwidth_error_evt)
            bw_err_q <= 1'b1;
         else if (bw_clr)
            bw_err_q <= 1'b0;
         if (stream_underrun_flag | (refresh_underrun_evt & is_refresh))
            underrun_flag_q <= 1'b1;
         else if (underrun_flag_clr)
            underrun_flag_q <= 1'b0;
      end
   end

   // ==========================================================
   // read data
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (ctrl_sel) begin
         prdata_d[CLK_SRC_LSB +: 2] = clk_src_q;
         prdata_d[IN_DIV_LSB +: 3]  = in_div_q;
         prdata_d[FB_DIV_LSB +: 3]  = fb_div_q;
         prdata_d[CLK_DRIVE_BIT]    = drive_q;
         prdata_d[SYNC_MASTER_BIT]  = sync_master_q;
         prdata_d[LINE_POL_BIT]     = line_pol_q;
         prdata_d[FRAME_POL_BIT]    = frame_pol_q;
         prdata_d[OVERLAY_BIT]      = overlay_q;
         prdata_d[MODE_LSB +: 3]    = mode_q;
         prdata_d[ENABLE_BIT]       = enable_q;
      end else if (stat_sel) begin
         prdata_d[ST_DRAINED1_BIT]  = drained1_q;
         prdata_d[ST_DRAINED2_BIT]  = drained2_q;
         prdata_d[ST_BW_ERR_BIT]    = bw_err_q;
         prdata_d[ST_UNDERRUN_FLAG_BIT]      = underrun_flag_q;
         prdata_d[ST_ACTIVE2_BIT]   = active2_q;
      end
   end
   // gated by psel so the bus idles at zero between reads
   assign prdata = (psel & ~pwrite) ? prdata_d : 32'h0000_0000;

   // ==========================================================
   // pixel clock routing
   // unit_clock is the chosen source with drive set, or pixel_clock_i with drive clear, sampled on pclk; a limitation:
   // a source above half the pclk rate will alias
   logic src_sel;
   always_comb begin
      case (clk_src_q)
         SRC_PLL_VCO: src_sel = pll_vco_clk;
         SRC_FB_DIV:  src_sel = pll_fb_div_clk;
         SRC_IN_DIV:  src_sel = pll_in_div_clk;
         SRC_SYNTH:   src_sel = synth_clk;
         default:     src_sel = synth_clk;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_cfg         <= '{SRC_SYNTH, 4'h0, 4'h0};
         pixel_clock_pin <= '{1'b0, 1'b1};
         unit_clock      <= 1'b0;
      end else begin
         // registered: the pll sees one clean update per write
         pll_cfg.src      <= clk_src_q;
         pll_cfg.in_ratio <= {1'b0, in_div_q} + 4'h1;
         pll_cfg.fb_ratio <= {1'b0, fb_div_q} + 4'h1;
         pixel_clock_pin  <= '{src_sel, ~drive_q};
         unit_clock       <= drive_q ? src_sel : pixel_clock_i;
      end
   end

   // ==========================================================
   // sync pins and frame reference
   logic frame_in_q;
   logic frame_edge;
   // the first sample after reset only primes the history, so a pin
   // that idles high cannot fake a rising edge
   logic frame_primed_q;
   assign frame_edge = frame_pol_q ? (frame_sync_i & ~frame_in_q)
                                   : (~frame_sync_i & frame_in_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_in_q      <= 1'b0;
         frame_primed_q  <= 1'b0;
         frame_ref_pulse <= 1'b0;
         // pins leave reset as inputs: the far side may be driving
         line_sync_pin   <= '{1'b0, 1'b1};
         frame_sync_pin  <= '{1'b0, 1'b1};
      end else begin
         frame_in_q      <= frame_sync_i;
         frame_primed_q  <= 1'b1;
         frame_ref_pulse <= frame_edge & frame_primed_q & ~sync_master_q &
                            is_refresh;
         // in transfer modes the same pins carry message start and end
         // timing when master
         line_sync_pin   <= '{is_refresh ? line_timing : msg_start,
                              ~sync_master_q};
         frame_sync_pin  <= '{is_refresh ? frame_timing : msg_end,
                              ~sync_master_q};
      end
   end

   // ==========================================================
   // mode outputs
   // all mode outputs except second_buffer_active move together one edge after the write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overlay_active       <= 1'b0;
         mode                 <= MODE_REFRESH_A;
         unit_enable          <= 1'b0;
         buffer_ready         <= 2'b00;
         second_buffer_active <= 1'b0;
      end else begin
         overlay_active       <= overlay_q & is_refresh;
         mode                 <= mode_q;
         unit_enable          <= enable_q;
         buffer_ready         <= {~drained2_q, ~drained1_q};
         second_buffer_active <= active2_q;
      end
   end

   // line_sync_i is sampled by nobody: the first pin's input side has
   // no function while it is not driven
   logic unused_in;
   assign unused_in = line_sync_i & line_pol_q;

endmodule
`default_nettype wire

// ===== video_out_control_fields_properties.sv
`timescale 1ns/1ps
`default_nettype none
module video_out_control_fields_properties
   import video_out_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pslverr,
   input wire video_out_pkg::pll_cfg_t pll_cfg,
   input wire video_out_pkg::pin_out_t pixel_clock_pin,
   input wire video_out_pkg::pin_out_t line_sync_pin,
   input wire video_out_pkg::pin_out_t frame_sync_pin,
   input wire logic                    overlay_active,
   input wire video_out_pkg::mode_t    mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_c;
   // ==========
   // control write; derived outputs land two edges on
   assign wr_c = psel & penable & pwrite & (paddr == CTRL_OFFSET);
   property p_src; wr_c |=> ##1 pll_cfg.src == $past(pwdata[29:28], 2);
   endproperty
   a_src: assert property (p_src) else $error("clock source wrong");
   property p_in;
      wr_c |=> ##1 pll_cfg.in_ratio == {1'b0, $past(pwdata[27:25], 2)} + 4'h1;
   endproperty
   a_in: assert property (p_in) else $error("input ratio wrong");
   property p_fb;
      wr_c |=> ##1 pll_cfg.fb_ratio == {1'b0, $past(pwdata[24:22], 2)} + 4'h1;
   endproperty
   a_fb: assert property (p_fb) else $error("feedback ratio wrong");
   property p_clk;
      wr_c |=> ##1 pixel_clock_pin.oe_n == !$past(pwdata[21], 2);
   endproperty
   a_clk: assert property (p_clk) else $error("clock pin dir wrong");
   property p_sync; wr_c |=> ##1 frame_sync_pin.oe_n == !$past(pwdata[20], 2)
      && line_sync_pin.oe_n == frame_sync_pin.oe_n; endproperty
   a_sync: assert property (p_sync) else $error("sync dir wrong");
   property p_mode; wr_c |=> ##1 mode == $past(pwdata[16:14], 2); endproperty
   a_mode: assert property (p_mode) else $error("mode wrong");
   // overlay is gated off in the transfer modes
   property p_ovl; wr_c |=> ##1
      overlay_active == ($past(pwdata[17], 2) && !$past(pwdata[16], 2));
   endproperty
   a_ovl: assert property (p_ovl) else $error("overlay wrong");
   property p_rz;
      psel && !pwrite && paddr == CTRL_OFFSET |-> prdata[13:10] == 4'h0;
   endproperty
   a_rz: assert property (p_rz) else $error("action bits read back");
   property p_err; psel && penable && paddr != CTRL_OFFSET
      && paddr != STATUS_OFFSET |-> pslverr && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   c_drv: cover property (wr_c && pwdata[CLK_DRIVE_BIT]);
   c_err: cover property (pslverr);
   c_ovl: cover property (overlay_active);
endmodule
bind video_out_control_fields video_out_control_fields_properties u_props (.*);
`default_nettype wire

// ===== video_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module video_device_model
   import video_out_pkg::*;
(
   input  wire logic                    pclk,
   input  wire video_out_pkg::pin_out_t pixel_clock_pin,
   input  wire video_out_pkg::pin_out_t line_sync_pin,
   input  wire video_out_pkg::pin_out_t frame_sync_pin,
   input  wire logic                    frame_level,
   output logic                         pixel_clock_i,
   output logic                         line_sync_i,
   output logic                         frame_sync_i
);
   logic [2:0] div_q = 3'h0;
   logic       ext_q = 1'b0;
   logic       tog_q = 1'b0;
   // external pixel clock, slow so every level is seen by the unit
   always_ff @(posedge pclk) begin
      div_q <= div_q + 3'h1;
      ext_q <= ext_q ^ (div_q == 3'h7);
   end
   // a released line pin has no pull: show a moving level
   always_ff @(posedge pclk) begin
      tog_q <= ~tog_q;
   end
   // external clock while pin is an input
   assign pixel_clock_i = pixel_clock_pin.oe_n ? ext_q : pixel_clock_pin.o;
   // frame reference only while pin is an input
   assign frame_sync_i = frame_sync_pin.oe_n ? frame_level : frame_sync_pin.o;
   assign line_sync_i = line_sync_pin.oe_n ? tog_q : line_sync_pin.o;
endmodule
`default_nettype wire

// ===== video_out_control_fields_tb.sv
`timescale 1ns/1ps
`default_nettype none
module video_out_control_fields_tb;
   import video_out_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic        pixel_clock_i, line_sync_i, frame_sync_i, frame_level;
   logic        unit_clock, frame_ref_pulse, overlay_active, unit_enable;
   logic        second_buffer_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, w;
   logic [3:0]  srcs;
   logic [3:0]  tim;
   logic [2:0]  ev;
   logic [1:0]  buffer_ready;
   pll_cfg_t    pll_cfg;
   pin_out_t    pixel_clock_pin, line_sync_pin, frame_sync_pin;
   mode_t       mode;
   int          mismatches, n_tests, pulses, c0, c1;
   video_out_control_fields u_dut (.*, .pll_vco_clk(srcs[0]),
      .pll_fb_div_clk(srcs[1]), .pll_in_div_clk(srcs[2]), .synth_clk(srcs[3]),
      .line_timing(tim[3]), .frame_timing(tim[2]), .msg_start(tim[1]),
      .msg_end(tim[0]), .buffer_done(ev[0]), .bandwidth_error_evt(ev[1]),
      .refresh_underrun_evt(ev[2]));
   video_device_model u_dev (.*);
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   // count frame reference pulses without racing the readers
   always @(posedge pclk) if (frame_ref_pulse === 1'b1) pulses <= pulses + 1;
   // ==========
   // apb master: setup, then access until pready
   task automatic xf(input logic [11:0] a, input logic wr,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      q = prdata;
      e = pslverr;
      if (n >= 64) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] x,
                      input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", s, x, g);
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] x);
      xf(a, 1'b0, 32'h0);
      chk($sformatf("read %h", a), x, q & m);
   endtask
   task automatic pul(input logic [2:0] v);
      ev <= v;
      @(posedge pclk);
      ev <= 3'h0;
      @(posedge pclk);
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      {psel, penable, pwrite, presetn, frame_level} = 5'h0;
      {paddr, pwdata, srcs, tim, ev} = 0;
      {mismatches, n_tests, pulses} = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rc(CTRL_OFFSET, 32'hFFFF_FFFF, 32'h3240_0000);
      rc(STATUS_OFFSET, 32'hF, 32'h3);
      chk("pll", {22'h0, SRC_SYNTH, 8'h22}, {22'h0, pll_cfg});
      chk("pins", 32'h15, {26'h0, pixel_clock_pin, line_sync_pin,
         frame_sync_pin});
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         srcs <= 4'h1 << i;
         w = (i << 28) | ((i + 2) << 25) | ((i + 3) << 22) | 32'h0020_0000;
         xf(CTRL_OFFSET, 1'b1, w);
         repeat (2) @(posedge pclk);
         chk("pll", {22'h0, 2'(i), 4'(i + 3), 4'(i + 4)},
            {22'h0, pll_cfg});
         chk("unit_clock", 32'h1, {31'h0, unit_clock});
         chk("clk_oe_n", 32'h0, {31'h0, pixel_clock_pin.oe_n});
         chk("clk_pin", 32'h1, {31'h0, pixel_clock_pin.o});
      end
      $display("test clock source done");
      for (int p = 0; p < 2; p++) begin
         xf(CTRL_OFFSET, 1'b1, (p << FRAME_POL_BIT) | ((1 - p) << LINE_POL_BIT));
         repeat (4) @(posedge pclk);
         // drive enable is clear: the unit runs from the external clock
         repeat (16) begin
            w = {31'h0, pixel_clock_i};
            @(posedge pclk);
            chk("ext_clock", w, {31'h0, unit_clock});
         end
         c0 = pulses;
         frame_level <= 1'b1;
         repeat (8) @(posedge pclk);
         c1 = pulses;
         frame_level <= 1'b0;
         repeat (8) @(posedge pclk);
         chk("rise", p, c1 - c0);
         chk("fall", 1 - p, pulses - c1);
      end
      pul(3'h4);
      rc(STATUS_OFFSET, 32'h8, 32'h8);
      xf(CTRL_OFFSET, 1'b1, 32'h0000_0400);
      rc(STATUS_OFFSET, 32'h8, 32'h0);
      $display("test frame edge done");
      tim <= 4'b0110;
      for (int m = 0; m < 6; m++) begin
         xf(CTRL_OFFSET, 1'b1, 32'h0012_0000 | (m << MODE_LSB));
         repeat (2) @(posedge pclk);
         chk("sync", {24'h0, m < 4, 3'(m), m < 4 ? 4'h2 : 4'h8}, {24'h0,
            overlay_active, mode, line_sync_pin, frame_sync_pin});
      end
      $display("test modes done");
      xf(CTRL_OFFSET, 1'b1, 32'h0011_0000);
      // mode is set apart from enable, then five pixel clocks pass
      repeat (80) @(posedge pclk);
      xf(CTRL_OFFSET, 1'b1, 32'h0011_1001);
      repeat (2) @(posedge pclk);
      chk("ready", 32'h5, {29'h0, unit_enable, buffer_ready});
      rc(STATUS_OFFSET, 32'h3, 32'h2);
      pul(3'h1);
      rc(STATUS_OFFSET, 32'h3, 32'h3);
      xf(CTRL_OFFSET, 1'b1, 32'h0011_4000);
      repeat (80) @(posedge pclk);
      xf(CTRL_OFFSET, 1'b1, 32'h0011_4001);
      repeat (2) @(posedge pclk);
      chk("ready", 32'h7, {29'h0, unit_enable, buffer_ready});
      rc(STATUS_OFFSET, 32'h3, 32'h0);
      pul(3'h1);
      rc(STATUS_OFFSET, 32'h3, 32'h1);
      chk("active2", 32'h1, {31'h0, second_buffer_active});
      xf(CTRL_OFFSET, 1'b1, 32'h0011_6000);
      rc(STATUS_OFFSET, 32'h3, 32'h0);
      pul(3'h1);
      rc(STATUS_OFFSET, 32'hB, 32'h2);
      pul(3'h1);
      rc(STATUS_OFFSET, 32'h8, 32'h8);
      pul(3'h2);
      rc(STATUS_OFFSET, 32'hC, 32'hC);
      xf(CTRL_OFFSET, 1'b1, 32'h0011_4C00);
      rc(STATUS_OFFSET, 32'hC, 32'h0);
      rc(CTRL_OFFSET, 32'hFFFF_FFFF, 32'h0011_4000);
      $display("test buffers done");
      rc(12'h008, 32'hFFFF_FFFF, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      $display("test unmapped done");
      complete_run();
   end
   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      #20000;
      mismatches++;
      complete_run();
   end
endmodule
`default_nettype wire
